//--- hdl/scmc_counter.sv
/*
 saturating up-counter with clear; flags when the limit has been reached.
 assumes LIMIT fits in W bits.
*/
`timescale 1ns/1ps
module scmc_counter #(
	parameter int W = 16,
	parameter int LIMIT = 100
) (
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic clear,
	input  wire logic run,
	output logic      done
);

	logic [W-1:0] cnt_ff;

	assign done = (cnt_ff == W'(LIMIT));

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			cnt_ff <= '0;
		else if (clear)
			cnt_ff <= '0;
		else if (run && !done)
			cnt_ff <= cnt_ff + W'(1);
	end

endmodule

//--- hdl/scmc_pkg.sv
/*
 package for the supercapacitor charger mode control: modes, timing constants,
 comparator and control bundles.
 assumes a 200 MHz core clock; no bus, all control bits are plain ports.
*/
package scmc_pkg;

	localparam int CLK_MHZ = 200;
	// overcurrent deglitch, in microseconds
	localparam int OCP_DGL_US = 100;
	localparam int OCP_DGL_CYC = OCP_DGL_US * CLK_MHZ;
	// status blink: 1 Hz period, half period per phase
	localparam int BLINK_HZ = 1;
	localparam int BLINK_HALF_CYC = (CLK_MHZ * 1000000) / (2 * BLINK_HZ);
	// set-check count; the mode stays on the current-set pin check for one cycle more than this
	localparam int SET_CHECK_CYC = 16;
	// thermal thresholds in degrees Celsius
	localparam int TEMP_REG_C = 125;
	localparam int TEMP_SHUT_RISE_C = 150;
	localparam int TEMP_SHUT_FALL_C = 135;
	localparam int TEMP_W = 8;

	typedef enum logic [2:0] {
		ST_SHUTDOWN,
		ST_SLEEP,
		ST_SET_CHECK,
		ST_ACTIVE,
		ST_STANDBY,
		ST_FAULT
	} scmc_mode_t;

	// comparator results, all raw and asynchronous to core_clk
	typedef struct packed {
		logic input_low_ok;        // input above input_low_level
		logic above_sleep;         // input above output plus sleep_margin
		logic input_overvoltage;   // input above input_overvoltage_level
		logic overcurrent;         // output above output_overcurrent_level
		logic set_short;           // current_set_pin below set_resistor_short_limit
		logic set_open;            // current_set_pin open
		logic fb_charged;          // feedback_input above 98% of feedback_reference
	} scmc_cmp_t;

	// regulator steering
	typedef struct packed {
		logic bias_on;
		logic regulator_on;
		logic current_enable;
		logic thermal_fold;
	} scmc_reg_t;

endpackage

//--- hdl/scmc_sync.sv
/*
 two-flop synchroniser bank for asynchronous comparator and pin levels.
 assumes levels only; pulses shorter than one clock may be lost.
*/
`timescale 1ns/1ps
module scmc_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_ff;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_ff <= '0;
			q <= '0;
		end
		else
		begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end

endmodule

//--- hdl/scmc_top.sv
/*
 mode and fault sequencing for a supercapacitor linear charger: power-up order,
 sleep/active/standby/fault modes, latched faults, thermal control and the
 open-drain status pins.
 assumes comparator levels arrive asynchronously and are synchronised here;
 the analog loops themselves sit outside and follow the regulator controls.
*/
`timescale 1ns/1ps
// Overview of operation
// - With valid input and enabled, check current-set pin, then start regulator.
// - Shorted set resistor at startup latches fault until input or disable toggles.
// - Open set pin still completes detection and starts with zero current.
// - Set pin watched while charging; current follows it at once.
// - Status high below 98%, low above, 1 Hz blink on faults.
// - Power good low only when input valid, not asleep, not overvoltage.
// - Input overvoltage enters standby, charging resumes when input normal.
// - Overcurrent past deglitch latches off until input or disable toggles.
// - Overcurrent deglitch is 100 microseconds of continuous excess current.
// - Above regulation temperature, charge current is folded back.
// - Regulator off above shutdown rising, back on below falling threshold.
// - Thresholds 150 C rising, 135 C falling, regulation 125 C.
// - Below low-input level: shutdown, all pins released.
// - Input above low level but below output plus margin: sleep.
// - Active charging only with disable low and input above both levels; leaving standby enters active for a cycle without checking either.
// - Standby stays partially biased and keeps checking the fault.
// - Constant current then constant voltage; no termination on low current.
// - Disable input pulled low internally, so open means enabled.
module scmc_top #(
	parameter int OCP_DGL_CYC = scmc_pkg::OCP_DGL_CYC,
	parameter int BLINK_HALF_CYC = scmc_pkg::BLINK_HALF_CYC
) (
	input  wire logic                          core_clk,
	input  wire logic                          rstn,
	input  wire scmc_pkg::scmc_cmp_t           cmp_raw,
	input  wire logic                          charge_disable,
	input  wire logic [scmc_pkg::TEMP_W-1:0]   die_temp_c,
	output scmc_pkg::scmc_reg_t                reg_ctl,
	output scmc_pkg::scmc_mode_t               mode,
	output logic                               power_good_n_o,
	output logic                               power_good_n_oe,
	output logic                               charge_status_o,
	output logic                               charge_status_oe,
	output logic                               cc_phase,
	output logic                               latched_fault
);

	////////////////////////////////////////////////////////////////////////////
	// input synchronisation

	localparam int NCMP = $bits(scmc_pkg::scmc_cmp_t);
	localparam int NSYN = NCMP + 1 + scmc_pkg::TEMP_W;

	scmc_pkg::scmc_cmp_t          cmp;
	logic                         dis_s;
	logic [scmc_pkg::TEMP_W-1:0]  temp_s;

	// temperature word is slow-moving; a torn sample only shifts one compare by a cycle
	scmc_sync #(.W(NSYN)) u_sync (
		.core_clk (core_clk),
		.rstn     (rstn),
		.d        ({cmp_raw, charge_disable, die_temp_c}),
		.q        ({cmp, dis_s, temp_s})
	);

	////////////////////////////////////////////////////////////////////////////
	// input validity and toggle detection

	logic input_ok;
	logic powered;
	logic dis_q_ff;
	logic pwr_q_ff;
	logic relatch;

	// an undriven disable pin reads low through the pulldown, so low means enable
	assign powered = cmp.input_low_ok;
	assign input_ok = cmp.input_low_ok && cmp.above_sleep;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dis_q_ff <= 1'b0;
			pwr_q_ff <= 1'b0;
		end
		else
		begin
			dis_q_ff <= dis_s;
			pwr_q_ff <= powered;
		end
	end

	// a rise of disable or a drop of input clears latched faults
	assign relatch = (dis_s && !dis_q_ff) || (!powered && pwr_q_ff);

	////////////////////////////////////////////////////////////////////////////
	// overcurrent deglitch and startup check timers

	logic ocp_done;
	logic chk_done;
	logic in_active;

	scmc_counter #(.W(32), .LIMIT(OCP_DGL_CYC)) u_ocp_dgl (
		.core_clk (core_clk),
		.rstn     (rstn),
		.clear    (!cmp.overcurrent),
		.run      (in_active),
		.done     (ocp_done)
	);

	scmc_pkg::scmc_mode_t mode_ff;
	scmc_pkg::scmc_mode_t nxt_mode;

	scmc_counter #(.W(8), .LIMIT(scmc_pkg::SET_CHECK_CYC)) u_chk (
		.core_clk (core_clk),
		.rstn     (rstn),
		.clear    (mode_ff != scmc_pkg::ST_SET_CHECK),
		.run      (1'b1),
		.done     (chk_done)
	);

	assign in_active = (mode_ff == scmc_pkg::ST_ACTIVE) && cmp.overcurrent;

	////////////////////////////////////////////////////////////////////////////
	// thermal shutdown with hysteresis

	logic tshut_ff;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			tshut_ff <= 1'b0;
		else if (temp_s > scmc_pkg::TEMP_W'(scmc_pkg::TEMP_SHUT_RISE_C))
			tshut_ff <= 1'b1;
		else if (temp_s < scmc_pkg::TEMP_W'(scmc_pkg::TEMP_SHUT_FALL_C))
			tshut_ff <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// mode sequencing

	always_comb
	begin
		nxt_mode = mode_ff;
		if (!powered)
			nxt_mode = scmc_pkg::ST_SHUTDOWN;
		else
		begin
			unique case (mode_ff)
				scmc_pkg::ST_SHUTDOWN,
				scmc_pkg::ST_SLEEP:
				begin
					if (!cmp.above_sleep)
						nxt_mode = scmc_pkg::ST_SLEEP;
					else if (!dis_s)
						nxt_mode = scmc_pkg::ST_SET_CHECK;
					else
						nxt_mode = scmc_pkg::ST_SLEEP;
				end
				scmc_pkg::ST_SET_CHECK:
				begin
					if (dis_s || !cmp.above_sleep)
						nxt_mode = scmc_pkg::ST_SLEEP;
					else if (cmp.set_short)
						nxt_mode = scmc_pkg::ST_FAULT;
					else if (chk_done)
						nxt_mode = scmc_pkg::ST_ACTIVE;
				end
				scmc_pkg::ST_ACTIVE:
				begin
					if (ocp_done)
						nxt_mode = scmc_pkg::ST_FAULT;
					else if (cmp.input_overvoltage)
						nxt_mode = scmc_pkg::ST_STANDBY;
					else if (dis_s || !cmp.above_sleep)
						nxt_mode = scmc_pkg::ST_SLEEP;
				end
				scmc_pkg::ST_STANDBY:
				begin
					if (!cmp.input_overvoltage)
						nxt_mode = scmc_pkg::ST_ACTIVE;
				end
				scmc_pkg::ST_FAULT:
				begin
					if (relatch)
						nxt_mode = scmc_pkg::ST_SLEEP;
				end
				default:
					nxt_mode = scmc_pkg::ST_SHUTDOWN;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			mode_ff <= scmc_pkg::ST_SHUTDOWN;
		else
			mode_ff <= nxt_mode;
	end

	assign mode = mode_ff;
	assign latched_fault = (mode_ff == scmc_pkg::ST_FAULT);

	////////////////////////////////////////////////////////////////////////////
	// regulator controls

	scmc_pkg::scmc_reg_t reg_ff;
	logic                active;

	assign active = (mode_ff == scmc_pkg::ST_ACTIVE);

	// current enable follows the live open-pin compare, so no restart is needed
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			reg_ff <= '0;
		else
		begin
			reg_ff.bias_on <= active || mode_ff == scmc_pkg::ST_STANDBY
				|| mode_ff == scmc_pkg::ST_SET_CHECK;
			reg_ff.regulator_on <= active && !tshut_ff;
			reg_ff.current_enable <= active && !tshut_ff && !cmp.set_open;
			reg_ff.thermal_fold <= temp_s
				> scmc_pkg::TEMP_W'(scmc_pkg::TEMP_REG_C);
		end
	end

	assign reg_ctl = reg_ff;

	// no low-current termination: phase reflects only regulator_on and the charged compare
	assign cc_phase = reg_ff.regulator_on && !cmp.fb_charged;

	////////////////////////////////////////////////////////////////////////////
	// blink and open-drain status pins

	logic [31:0] blink_cnt_ff;
	logic        blink_ff;
	logic        pg_oe_ff;
	logic        st_oe_ff;
	logic        blink_fault;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			blink_cnt_ff <= '0;
			blink_ff <= 1'b0;
		end
		else if (blink_cnt_ff == 32'(BLINK_HALF_CYC - 1))
		begin
			blink_cnt_ff <= '0;
			blink_ff <= !blink_ff;
		end
		else
			blink_cnt_ff <= blink_cnt_ff + 32'h1;
	end

	assign blink_fault = mode_ff == scmc_pkg::ST_FAULT || mode_ff == scmc_pkg::ST_STANDBY;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pg_oe_ff <= 1'b0;
			st_oe_ff <= 1'b0;
		end
		else
		begin
			pg_oe_ff <= input_ok && !cmp.input_overvoltage;
			if (!powered)
				st_oe_ff <= 1'b0;
			else if (blink_fault)
				st_oe_ff <= blink_ff;
			else
				st_oe_ff <= cmp.fb_charged;
		end
	end

	assign power_good_n_o = 1'b0;
	assign power_good_n_oe = pg_oe_ff;
	assign charge_status_o = 1'b0;
	assign charge_status_oe = st_oe_ff;

	////////////////////////////////////////////////////////////////////////////
	// checks

	logic [31:0] ocp_hold_ff; // kept apart from the counter that it checks
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			ocp_hold_ff <= '0;
		else
			ocp_hold_ff <= cmp.overcurrent ? ocp_hold_ff + 32'(active) : 32'h0;
	end

	sequence standby_stop_s;
		mode_ff == scmc_pkg::ST_STANDBY ##1 !reg_ff.regulator_on;
	endsequence

	ovc_latch_a: assert property (@(posedge core_clk) disable iff (!rstn)
		mode_ff == scmc_pkg::ST_FAULT && !relatch && powered
		|=> mode_ff == scmc_pkg::ST_FAULT)
		else $error("latched fault left without toggle");

	ovc_deglitch_a: assert property (@(posedge core_clk) disable iff (!rstn)
		active && ocp_hold_ff < 32'(OCP_DGL_CYC) |=> !latched_fault)
		else $error("overcurrent latched before deglitch");

	ovp_standby_a: assert property (@(posedge core_clk) disable iff (!rstn)
		active && cmp.input_overvoltage && !ocp_done && powered |=> standby_stop_s)
		else $error("overvoltage did not stop charging");

	set_check_a: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(active) |-> $past(mode_ff) inside {scmc_pkg::ST_SET_CHECK, scmc_pkg::ST_STANDBY})
		else $error("regulator started without set check");

	set_short_a: assert property (@(posedge core_clk) disable iff (!rstn)
		mode_ff == scmc_pkg::ST_SET_CHECK && cmp.set_short && !dis_s
		&& cmp.above_sleep && powered |=> latched_fault)
		else $error("set short not latched");

	tshut_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
		tshut_ff |=> !reg_ff.regulator_on)
		else $error("regulator on in thermal shutdown");

	pg_level_a: assert property (@(posedge core_clk) disable iff (!rstn)
		power_good_n_oe |-> $past(input_ok && !cmp.input_overvoltage))
		else $error("power good asserted with bad input");

	shutdown_pins_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!powered ##1 !powered |-> !charge_status_oe && mode_ff == scmc_pkg::ST_SHUTDOWN)
		else $error("pins driven in shutdown");

	open_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
		cmp.set_open |=> !reg_ff.current_enable)
		else $error("current enabled with open set pin");

endmodule

//--- test/scmc_supply.sv
/*
 far-side model: input source, supercapacitor, set resistor, die and the
 pull-ups on the two open-drain indicator pins.
 assumes the bench sets the analog levels; comparators follow at once.
*/
`timescale 1ns/1ps
module scmc_supply (
	input  wire logic [1:0] vin_level,
	input  wire logic       oc,
	input  wire logic       sshort,
	input  wire logic       sopen,
	input  wire logic       fbc,
	input  wire logic [7:0] temp,
	input  wire logic       power_good_n_oe,
	input  wire logic       charge_status_oe,
	output wire scmc_pkg::scmc_cmp_t cmp_raw,
	output logic [7:0]      die_temp_c,
	output logic            pg_pin,
	output logic            stat_pin
);
	// vin_level: 0 below low level, 1 sleep band, 2 normal, 3 overvoltage
	assign cmp_raw.input_low_ok = vin_level != 2'h0;
	assign cmp_raw.above_sleep = vin_level[1];
	assign cmp_raw.input_overvoltage = vin_level == 2'h3;
	assign cmp_raw.overcurrent = oc;
	assign cmp_raw.set_short = sshort;
	assign cmp_raw.set_open = sopen;
	assign cmp_raw.fb_charged = fbc;
	assign die_temp_c = temp;
	// pull-ups: a released pin reads high, never the last driven level
	assign pg_pin = power_good_n_oe ? 1'b0 : 1'b1;
	assign stat_pin = charge_status_oe ? 1'b0 : 1'b1;
endmodule

//--- test/scmc_top_tb.sv
/*
 self-checking bench for the charger mode control with a level model.
 assumes short deglitch and blink counts; inputs change on falling edges.
*/
`timescale 1ns/1ps
module scmc_top_tb;
	localparam int OCP = 20;
	localparam int BLK = 50;
	logic                 core_clk;
	logic                 rstn;
	logic                 charge_disable;
	logic [1:0]           vin_level;
	logic                 oc;
	logic                 sshort;
	logic                 sopen;
	logic                 fbc;
	logic [7:0]           temp;
	logic [7:0]           die_temp_c;
	scmc_pkg::scmc_cmp_t  cmp_raw;
	scmc_pkg::scmc_reg_t  reg_ctl;
	scmc_pkg::scmc_mode_t mode;
	logic                 pg_o;
	logic                 pg_oe;
	logic                 st_o;
	logic                 st_oe;
	logic                 cc_phase;
	logic                 latched_fault;
	logic                 pg_pin;
	logic                 stat_pin;
	logic                 st_prev;
	int                   bad_count;
	int                   check_count;
	integer               seed;
	int                   hot;
	int                   cnt;
	int                   tbl [7] = '{125, 126, 150, 151, 140, 135, 134};

	scmc_top #(.OCP_DGL_CYC(OCP), .BLINK_HALF_CYC(BLK)) i_dut (
		.core_clk(core_clk), .rstn(rstn), .cmp_raw(cmp_raw),
		.charge_disable(charge_disable), .die_temp_c(die_temp_c), .reg_ctl(reg_ctl),
		.mode(mode), .power_good_n_o(pg_o), .power_good_n_oe(pg_oe),
		.charge_status_o(st_o), .charge_status_oe(st_oe), .cc_phase(cc_phase),
		.latched_fault(latched_fault));

	scmc_supply i_far (
		.vin_level(vin_level), .oc(oc), .sshort(sshort), .sopen(sopen), .fbc(fbc),
		.temp(temp), .power_good_n_oe(pg_oe), .charge_status_oe(st_oe),
		.cmp_raw(cmp_raw), .die_temp_c(die_temp_c), .pg_pin(pg_pin), .stat_pin(stat_pin));

	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wait_mode(input scmc_pkg::scmc_mode_t m, input int n);
		int i;
		for (i = 0; i < n && mode !== m; i++)
			@(negedge core_clk);
		chk({5'h0, mode}, {5'h0, m});
		if (mode !== m)
			complete_run();
	endtask

	// pins against the level model; power good needs only the input band
	task automatic settle();
		repeat (8) @(negedge core_clk);
		chk({7'h0, pg_pin}, {7'h0, vin_level != 2'h2});
		if (mode === scmc_pkg::ST_ACTIVE)
			chk({7'h0, stat_pin}, {7'h0, !fbc});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#400us;
		bad_count++;
		complete_run();
	end

	initial
	begin
		seed = 32'h7f6d;
		bad_count = 0;
		check_count = 0;
		hot = 0;
		rstn = 1'b0;
		charge_disable = 1'b0;
		vin_level = 2'h0;
		{oc, sshort, sopen, fbc} = 4'h0;
		temp = 8'h19;
		repeat (10) @(posedge core_clk);
		@(negedge core_clk);
		rstn = 1'b1;
		settle();
		chk({5'h0, mode}, {5'h0, scmc_pkg::ST_SHUTDOWN});
		chk({6'h0, pg_oe, st_oe}, 8'h00);
		vin_level = 2'h1;
		settle();
		chk({5'h0, mode}, {5'h0, scmc_pkg::ST_SLEEP});
		charge_disable = 1'b1;
		vin_level = 2'h2;
		settle();
		chk({5'h0, mode}, {5'h0, scmc_pkg::ST_SLEEP});
		chk({7'h0, reg_ctl.regulator_on}, 8'h00);
		charge_disable = 1'b0;
		sopen = 1'b1;
		wait_mode(scmc_pkg::ST_SET_CHECK, 10);
		chk({7'h0, reg_ctl.regulator_on}, 8'h00);
		wait_mode(scmc_pkg::ST_ACTIVE, 30);
		settle();
		chk({6'h0, reg_ctl.regulator_on, reg_ctl.current_enable}, 8'h02);
		sopen = 1'b0;
		settle();
		chk({4'h0, mode, reg_ctl.current_enable}, {4'h0, scmc_pkg::ST_ACTIVE, 1'b1});
		// fixed threshold temperatures first, then random ones; charge level random throughout
		for (int i = 0; i < 24; i++)
		begin
			temp = (i < 7) ? 8'(tbl[i]) : 8'(100 + ($unsigned($random(seed)) % 60));
			fbc = 1'($random(seed));
			if (temp > 8'd150)
				hot = 1;
			if (temp < 8'd135)
				hot = 0;
			settle();
			chk({7'h0, reg_ctl.regulator_on}, {7'h0, hot == 0});
			chk({7'h0, cc_phase}, {7'h0, hot == 0 && !fbc});
			if (hot == 0)
				chk({7'h0, reg_ctl.thermal_fold}, {7'h0, temp > 8'd125});
		end
		temp = 8'h19;
		fbc = 1'b0;
		settle();
		// short bursts: the deglitch count must restart on every drop
		repeat (4)
		begin
			oc = 1'b1;
			repeat (10) @(negedge core_clk);
			oc = 1'b0;
			repeat (5) @(negedge core_clk);
		end
		chk({5'h0, mode}, {5'h0, scmc_pkg::ST_ACTIVE});
		oc = 1'b1;
		repeat (OCP - 2) @(negedge core_clk);
		chk({5'h0, mode}, {5'h0, scmc_pkg::ST_ACTIVE});
		wait_mode(scmc_pkg::ST_FAULT, 20);
		oc = 1'b0;
		settle();
		chk({6'h0, latched_fault, reg_ctl.regulator_on}, 8'h02);
		cnt = 0;
		st_prev = st_oe;
		for (int i = 0; i < 4 * BLK + 20; i++)
		begin
			@(negedge core_clk);
			if (st_oe !== st_prev)
				cnt++;
			st_prev = st_oe;
		end
		chk({7'h0, cnt inside {[4:5]}}, 8'h01);
		charge_disable = 1'b1;
		settle();
		charge_disable = 1'b0;
		wait_mode(scmc_pkg::ST_ACTIVE, 40);
		vin_level = 2'h3;
		wait_mode(scmc_pkg::ST_STANDBY, 10);
		settle();
		chk({6'h0, reg_ctl.bias_on, reg_ctl.regulator_on}, 8'h02);
		vin_level = 2'h2;
		wait_mode(scmc_pkg::ST_ACTIVE, 40);
		vin_level = 2'h0;
		wait_mode(scmc_pkg::ST_SHUTDOWN, 10);
		sshort = 1'b1;
		vin_level = 2'h2;
		wait_mode(scmc_pkg::ST_FAULT, 40);
		sshort = 1'b0;
		settle();
		chk({5'h0, mode}, {5'h0, scmc_pkg::ST_FAULT});
		vin_level = 2'h0;
		wait_mode(scmc_pkg::ST_SHUTDOWN, 10);
		vin_level = 2'h2;
		wait_mode(scmc_pkg::ST_ACTIVE, 40);
		rstn = 1'b0;
		@(negedge core_clk);
		chk({5'h0, mode}, {5'h0, scmc_pkg::ST_SHUTDOWN});
		rstn = 1'b1;
		// a reset in mid-run must leave the sequencing able to start again
		wait_mode(scmc_pkg::ST_ACTIVE, 40);
		chk({6'h0, pg_o, st_o}, 8'h00);
		complete_run();
	end
endmodule
